// ---- rtl/iwd_pkg.sv ----
// Constants, register map and carrier types of the independent watchdog.
// Assumes a 50 MHz system clock and a Wishbone classic register bus.
package iwd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] IWD_OFF_REFRESH = 4'h0;
  localparam logic [3:0] IWD_OFF_CONTROL = 4'h4;
  localparam logic [3:0] IWD_OFF_RSTCTL = 4'h8;
  localparam logic [3:0] IWD_OFF_STOPCTL = 4'hC;

  // Status register sits outside the documented table; offset chosen here
  localparam logic [4:0] IWD_OFF_STATUS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int IWD_CTL_TOUT_LSB = 0;
  localparam int IWD_CTL_PRE_LSB = 4;
  localparam int IWD_CTL_WEND_LSB = 8;
  localparam int IWD_CTL_WSTART_LSB = 12;
  localparam int IWD_RST_SEL_BIT = 7;
  localparam int IWD_STP_SEL_BIT = 7;
  localparam int IWD_STS_UNDER_BIT = 14;
  localparam int IWD_STS_REFERR_BIT = 15;
  localparam logic [15:0] IWD_CONTROL_RESET = 16'h33F3;
  localparam logic [7:0] IWD_RSTCTL_RESET = 8'h00;
  localparam logic [7:0] IWD_STOPCTL_RESET = 8'h80;
  localparam logic [7:0] IWD_REFRESH_FIRST = 8'h00;
  localparam logic [7:0] IWD_REFRESH_SECOND = 8'hFF;
  localparam logic [13:0] IWD_COUNT_RESET = 14'h3FFF;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int IWD_CLK_MHZ = 50;
  localparam int IWD_PRE_WIDTH = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] prescaleSelect;
    logic [1:0] timeoutSelect;
    logic [1:0] windowStartSelect;
    logic [1:0] windowEndSelect;
    logic resetOrInterruptSelect;
    logic lowPowerCountStop;
  } iwd_cfg_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [4:0] adr;
    logic [31:0] dat;
  } iwd_wb_req_type;

  typedef struct packed {
    logic resetOut;
    logic nmiOut;
    logic irqOut;
    logic underflowEvent;
    logic refreshErrorEvent;
    logic sleepStopOut;
  } iwd_out_type;

  typedef enum logic [1:0] {
    IWD_SEQ_IDLE,
    IWD_SEQ_ARMED
  } iwd_seq_type;

  // Top value of the counter for a timeout selection
  function automatic logic [13:0] iwd_top(input logic [1:0] sel);
    case (sel)
      2'b00: iwd_top = 14'h03FF;
      2'b01: iwd_top = 14'h0FFF;
      2'b10: iwd_top = 14'h1FFF;
      default: iwd_top = 14'h3FFF;
    endcase
  endfunction : iwd_top

endpackage : iwd_pkg

// ---- rtl/iwd_prescaler.sv ----
// Prescaler of the watchdog count clock.
// Assumes the watchdog dedicated clock arrives as a synchronous tick input.
`timescale 1ns/1ps
module iwd_prescaler
  import iwd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [3:0] prescaleSelect,
  input wire logic sourceTick,
  // Result
  output logic countTick
);

  logic [IWD_PRE_WIDTH-1:0] divCount;
  logic [IWD_PRE_WIDTH-1:0] divLast;
  logic atLast;

  // ----------------------------------------------------------------
  // Ratio decode 1/16/32/64/128/256
  // ----------------------------------------------------------------
  // ratio select decode
  assign divLast = (prescaleSelect == 4'h2) ? 8'h0F :
                   (prescaleSelect == 4'h3) ? 8'h1F :
                   (prescaleSelect == 4'h4) ? 8'h3F :
                   (prescaleSelect == 4'hF) ? 8'h7F :
                   (prescaleSelect == 4'h5) ? 8'hFF : 8'h00;
  assign atLast = (divCount >= divLast);
  assign countTick = run && sourceTick && atLast;

  // Divider counts source ticks
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      divCount <= '0;
    else if (!run)
      divCount <= '0;
    else if (sourceTick)
      divCount <= atLast ? '0 : divCount + 8'h01;
  end

endmodule : iwd_prescaler

// ---- rtl/iwd_refresh_seq.sv ----
// Refresh sequencer: detects the two-write refresh pattern.
// Assumes one write strobe per accepted bus write to the refresh register.
`timescale 1ns/1ps
module iwd_refresh_seq
  import iwd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write strobe
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  // Result
  output logic refreshPulse
);

  iwd_seq_type state;
  iwd_seq_type next_state;
  logic isFirst;
  logic isSecond;

  assign isFirst = writeData == IWD_REFRESH_FIRST;
  assign isSecond = writeData == IWD_REFRESH_SECOND;

  // ----------------------------------------------------------------
  // Sequence decode
  // ----------------------------------------------------------------
  // FFh only right after 00h
  always_comb
  begin
    next_state = state;
    case (state)
      IWD_SEQ_IDLE:
        if (writeStrobe && isFirst)
          next_state = IWD_SEQ_ARMED;
      IWD_SEQ_ARMED:
        if (writeStrobe)
          next_state = isFirst ? IWD_SEQ_ARMED : IWD_SEQ_IDLE;
      default:
        next_state = IWD_SEQ_IDLE;
    endcase
  end

  assign refreshPulse = (state == IWD_SEQ_ARMED) && writeStrobe && isSecond;

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= IWD_SEQ_IDLE;
    else
      state <= next_state;
  end

endmodule : iwd_refresh_seq

// ---- rtl/independent_watchdog.sv ----
// Independent watchdog: windowed 14-bit down-counter with Wishbone registers.
// Assumes a 50 MHz clk, synchronous inputs, and a tick per dedicated clock edge.
//
// Summary of operation
// - Count clock is the dedicated clock divided by 1,16,32,64,128 or 256.
// - A 14-bit counter decrements once per prescaled tick while running.
// - Auto-start mode counts from reset release without software.
// - Writing 00h then FFh refreshes; register-start mode starts on it.
// - Reset stops the counter and restores counter and registers.
// - Register-start mode halts on underflow or refresh error until refresh.
// - Two-bit window start and end split each period into intervals.
// - Refresh outside the permitted interval is an error, like underflow.
// - Timeout select gives 1024, 4096, 8192 or 16384 cycles.
// - Select bit 1 gives reset output, 0 gives an interrupt.
// - Interrupt is non-maskable when the NMI enable is 1, else maskable.
// - Status register shows the current counter value.
// - Stop bit 1 halts counting in any low-power mode; 0 keeps counting.
// - Separate event pulses for underflow and for refresh error.
// - Auto-start settings come from the option-setting word.
// - Register-start settings come from the registers at the starting refresh.
// - Drives reset, interrupt and sleep count-stop outputs to the system.
`timescale 1ns/1ps
module independent_watchdog
  import iwd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [4:0] wbAdr,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Option word and system inputs
  input wire logic autoStartMode,
  input wire iwd_pkg::iwd_cfg_type optionSettingWordZero,
  input wire logic watchdogNmiEnable,
  input wire logic watchdogClockTick,
  input wire logic lowPowerRequest,
  // System outputs
  output iwd_pkg::iwd_out_type sysOut
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  iwd_wb_req_type req;
  logic [15:0] controlReg;
  logic [7:0] resetCtlReg;
  logic [7:0] stopCtlReg;
  iwd_cfg_type activeCfg;
  iwd_cfg_type regCfg;
  logic [13:0] counter;
  logic running;
  logic underflowFlag;
  logic refreshErrorFlag;
  logic autoPending;
  logic access;
  logic writeHit;
  logic wrRefresh;
  logic wrControl;
  logic wrRstCtl;
  logic wrStopCtl;
  logic mapped;
  logic [31:0] readMux;
  logic refreshPulse;
  logic countTick;
  logic stopNow;
  logic underflowNow;
  logic inWindow;
  logic refreshOk;
  logic refreshBad;
  logic faultNow;
  logic [13:0] topValue;
  logic [13:0] quarter;
  logic [13:0] startLimit;
  logic [13:0] endLimit;
  iwd_out_type next_sysOut;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Request bundle and address decode
  assign req = '{cyc: wbCyc, stb: wbStb, we: wbWe, sel: wbSel, adr: wbAdr, dat: wbDatIn};
  assign access = req.cyc && req.stb && !wbAck;
  // Writes commit on the edge after the acknowledge rises, where the master samples it
  assign writeHit = req.cyc && req.stb && req.we && wbAck;
  assign wrRefresh = writeHit && req.adr == {1'b0, IWD_OFF_REFRESH} && req.sel[0];
  assign wrControl = writeHit && req.adr == {1'b0, IWD_OFF_CONTROL} && (&req.sel[1:0]);
  assign wrRstCtl = writeHit && req.adr == {1'b0, IWD_OFF_RSTCTL} && req.sel[0];
  assign wrStopCtl = writeHit && req.adr == {1'b0, IWD_OFF_STOPCTL} && req.sel[0];
  assign mapped = (req.adr == {1'b0, IWD_OFF_REFRESH}) || (req.adr == {1'b0, IWD_OFF_CONTROL})
               || (req.adr == {1'b0, IWD_OFF_RSTCTL}) || (req.adr == {1'b0, IWD_OFF_STOPCTL})
               || (req.adr == IWD_OFF_STATUS);

  // Read data selection; unmapped reads return zero
  // counter readable
  assign readMux = (req.adr == {1'b0, IWD_OFF_CONTROL}) ? {16'h0000, controlReg} :
                   (req.adr == {1'b0, IWD_OFF_RSTCTL}) ? {24'h00_0000, resetCtlReg} :
                   (req.adr == {1'b0, IWD_OFF_STOPCTL}) ? {24'h00_0000, stopCtlReg} :
                   (req.adr == IWD_OFF_STATUS) ?
                     {16'h0000, refreshErrorFlag, underflowFlag, counter} :
                   (req.adr == {1'b0, IWD_OFF_REFRESH}) ? 32'h0000_00FF : 32'h0000_0000;

  // Single-cycle acknowledge with registered read data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wbAck <= 1'b0;
      wbDatOut <= '0;
    end
    else
    begin
      wbAck <= access;
      wbDatOut <= (access && mapped) ? readMux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // registers to initial values
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      controlReg <= IWD_CONTROL_RESET;
      resetCtlReg <= IWD_RSTCTL_RESET;
      stopCtlReg <= IWD_STOPCTL_RESET;
    end
    else
    begin
      if (wrControl)
        controlReg <= req.dat[15:0];
      if (wrRstCtl)
        resetCtlReg <= req.dat[7:0];
      if (wrStopCtl)
        stopCtlReg <= req.dat[7:0];
    end
  end

  // Register view of the settings
  // register-start settings
  assign regCfg = '{prescaleSelect: controlReg[IWD_CTL_PRE_LSB +: 4],
                    timeoutSelect: controlReg[IWD_CTL_TOUT_LSB +: 2],
                    windowStartSelect: controlReg[IWD_CTL_WSTART_LSB +: 2],
                    windowEndSelect: controlReg[IWD_CTL_WEND_LSB +: 2],
                    resetOrInterruptSelect: resetCtlReg[IWD_RST_SEL_BIT],
                    lowPowerCountStop: stopCtlReg[IWD_STP_SEL_BIT]};

  // ----------------------------------------------------------------
  // Refresh and prescaler
  // ----------------------------------------------------------------
  iwd_refresh_seq u_refresh (
    .clk(clk),
    .rstn(rstn),
    .writeStrobe(wrRefresh),
    .writeData(req.dat[7:0]),
    .refreshPulse(refreshPulse)
  );

  assign stopNow = activeCfg.lowPowerCountStop && lowPowerRequest;

  iwd_prescaler u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .run(running && !stopNow),
    .prescaleSelect(activeCfg.prescaleSelect),
    .sourceTick(watchdogClockTick),
    .countTick(countTick)
  );

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  // timeout period top
  assign topValue = iwd_top(activeCfg.timeoutSelect);
  // Widened by one bit so the longest period does not wrap to zero
  assign quarter = 14'(({1'b0, topValue} + 15'h0001) >> 2);
  // start 00/01/10/11 = 75/50/25/100 % left; end 00/01/10/11 = 75/50/25/0 % left
  assign startLimit = (activeCfg.windowStartSelect == 2'b11) ? topValue :
                      14'(quarter * (14'h0003 - {12'h000, activeCfg.windowStartSelect})
                          - 14'h0001);
  assign endLimit = 14'(quarter * (14'h0003 - {12'h000, activeCfg.windowEndSelect}));
  assign inWindow = counter <= startLimit && counter >= endLimit;

  assign refreshOk = refreshPulse && (!running || inWindow);
  assign refreshBad = refreshPulse && running && !inWindow;
  assign underflowNow = running && countTick && counter == 14'h0000;
  assign faultNow = underflowNow || refreshBad;

  // ----------------------------------------------------------------
  // Counter and run state
  // ----------------------------------------------------------------
  // auto-start after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      running <= 1'b0;
      autoPending <= 1'b1;
      counter <= IWD_COUNT_RESET;
      activeCfg <= '0;
    end
    else if (autoPending)
    begin
      autoPending <= 1'b0;
      if (autoStartMode)
      begin
        activeCfg <= optionSettingWordZero;
        counter <= iwd_top(optionSettingWordZero.timeoutSelect);
        running <= 1'b1;
      end
      else
        activeCfg <= regCfg;
    end
    else if (faultNow)
    begin
      running <= autoStartMode;
      counter <= topValue;
    end
    else if (refreshOk)
    begin
      running <= 1'b1;
      if (!autoStartMode && !running)
      begin
        activeCfg <= regCfg;
        counter <= iwd_top(regCfg.timeoutSelect);
      end
      else
        counter <= topValue;
    end
    else if (countTick)
      counter <= counter - 14'h0001;
  end

  // Sticky status flags; a fault wins over the clearing refresh
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      underflowFlag <= 1'b0;
      refreshErrorFlag <= 1'b0;
    end
    else
    begin
      underflowFlag <= underflowNow || (underflowFlag && !refreshOk);
      refreshErrorFlag <= refreshBad || (refreshErrorFlag && !refreshOk);
    end
  end

  // ----------------------------------------------------------------
  // System outputs
  // ----------------------------------------------------------------
  // reset or interrupt
  assign next_sysOut = '{resetOut: faultNow && activeCfg.resetOrInterruptSelect,
                         nmiOut: faultNow && !activeCfg.resetOrInterruptSelect
                                 && watchdogNmiEnable,
                         irqOut: faultNow && !activeCfg.resetOrInterruptSelect
                                 && !watchdogNmiEnable,
                         underflowEvent: underflowNow,
                         refreshErrorEvent: refreshBad,
                         sleepStopOut: activeCfg.lowPowerCountStop};

  // Registered outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sysOut <= '0;
    else
      sysOut <= next_sysOut;
  end

endmodule : independent_watchdog

// ---- sim/iwd_checker.sv ----
// Concurrent checks on the watchdog bus handshake and fault outputs.
// Assumes it is bound to the watchdog top module and sees its ports only.
`timescale 1ns/1ps
module iwd_checker
  import iwd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [4:0] wbAdr,
  input wire logic [31:0] wbDatIn,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  // System side
  input wire logic autoStartMode,
  input wire iwd_pkg::iwd_cfg_type optionSettingWordZero,
  input wire logic watchdogNmiEnable,
  input wire logic watchdogClockTick,
  input wire logic lowPowerRequest,
  input wire iwd_pkg::iwd_out_type sysOut
);
  import iwd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Fault pulse of either source
  wire fault;
  wire anyAction;
  assign fault = sysOut.underflowEvent || sysOut.refreshErrorEvent;
  assign anyAction = sysOut.resetOut || sysOut.nmiOut || sysOut.irqOut;
  AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (!(wbCyc && wbStb) |=> !wbAck)
    else $error("acknowledge without request");
  AST_DAT_IDLE: assert property (!wbAck |-> wbDatOut == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  AST_UNDER_PULSE: assert property (sysOut.underflowEvent |=> !sysOut.underflowEvent)
    else $error("underflow event longer than one cycle");
  AST_ERR_PULSE: assert property ($rose(sysOut.refreshErrorEvent) |=> $fell(sysOut.refreshErrorEvent))
    else $error("refresh error event longer than one cycle");
  AST_ONE_ACTION: assert property (fault |-> $onehot({sysOut.resetOut, sysOut.nmiOut, sysOut.irqOut}))
    else $error("fault without exactly one action output");
  AST_ACTION_CAUSE: assert property (anyAction |-> fault)
    else $error("action output without fault event");
  AST_NMI_SEL: assert property (sysOut.nmiOut |-> $past(watchdogNmiEnable))
    else $error("nmi issued while nmi enable low");
  AST_IRQ_SEL: assert property (sysOut.irqOut |-> !$past(watchdogNmiEnable))
    else $error("maskable irq issued while nmi enable high");
endmodule : iwd_checker

bind independent_watchdog iwd_checker u_chk (.clk, .rstn, .wbCyc, .wbStb, .wbWe, .wbSel,
  .wbAdr, .wbDatIn, .wbDatOut, .wbAck, .autoStartMode, .optionSettingWordZero,
  .watchdogNmiEnable, .watchdogClockTick, .lowPowerRequest, .sysOut);

// ---- sim/tb_independent_watchdog.sv ----
// Self-checking bench of the watchdog: registers, counting, window and faults.
// Assumes the watchdog design and its bound checker are compiled before it.
`timescale 1ns/1ps
module tb_independent_watchdog;
  import iwd_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk = 0, rstn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic [3:0] wbSel = 4'hF;
  logic [4:0] wbAdr = 5'h00;
  logic [31:0] wbDatIn = 32'h0000_0000, wbDatOut, rdData;
  logic autoStartMode = 0, watchdogNmiEnable = 0, watchdogClockTick = 0, lowPowerRequest = 0;
  iwd_cfg_type optionSettingWordZero = '0;
  iwd_out_type sysOut;
  int mismatches = 0, n_checks = 0, nUnder = 0, nErr = 0, nRst = 0, nNmi = 0, nIrq = 0;
  independent_watchdog u_dut (.clk, .rstn, .wbCyc, .wbStb, .wbWe, .wbSel, .wbAdr, .wbDatIn,
    .wbDatOut, .wbAck, .autoStartMode, .optionSettingWordZero, .watchdogNmiEnable,
    .watchdogClockTick, .lowPowerRequest, .sysOut);
  // Clock of 20 ns
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Counts fault pulses at the system outputs
  always @(posedge clk)
  begin
    nUnder <= nUnder + int'(sysOut.underflowEvent === 1'b1);
    nErr <= nErr + int'(sysOut.refreshErrorEvent === 1'b1);
    nRst <= nRst + int'(sysOut.resetOut === 1'b1);
    nNmi <= nNmi + int'(sysOut.nmiOut === 1'b1);
    nIrq <= nIrq + int'(sysOut.irqOut === 1'b1);
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Classic single cycle, held until ack is sampled
  task automatic wbCycle(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int waitCount;
    waitCount = 0;
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatIn <= dat;
    @(posedge clk);
    while (wbAck !== 1'b1 && waitCount < 20)
    begin
      waitCount++;
      @(posedge clk);
    end
    rdData = wbDatOut;
    if (waitCount == 20)
      check("ack wait", 1, 0);
    wbCyc <= 0;
    wbStb <= 0;
    wbWe <= 0;
    @(posedge clk);
  endtask : wbCycle
  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    wbCycle(1'b1, adr, dat);
  endtask : wr
  task automatic cnt(input string name, input logic [13:0] exp);
    wbCycle(1'b0, 5'h10, 32'h0000_0000);
    check(name, {18'h0_0000, exp}, {18'h0_0000, rdData[13:0]});
  endtask : cnt
  task automatic refresh;
    wr(5'h00, 32'h0000_0000);
    wr(5'h00, 32'h0000_00FF);
  endtask : refresh
  task automatic ticks(input int n);
    repeat (n)
    begin
      watchdogClockTick <= 1;
      @(posedge clk);
    end
    watchdogClockTick <= 0;
    repeat (4) @(posedge clk);
  endtask : ticks
  task automatic doReset(input logic isAuto);
    rstn <= 0;
    autoStartMode <= isAuto;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
  endtask : doReset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [4:0] adrs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
    logic [31:0] exps [6] = '{32'h0000_00FF, 32'h0000_33F3, 32'h0000_0000, 32'h0000_0080,
      32'h0000_3FFF, 32'h0000_0000};
    doReset(0);
    wr(5'h14, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++)
    begin
      wbCycle(1'b0, adrs[i], 32'h0000_0000);
      check("reset value", exps[i], rdData);
    end
    wr(5'h04, 32'h0000_1122);
    wbCycle(1'b0, 5'h04, 32'h0000_0000);
    check("control fields", 32'h0000_1122, rdData);
    wbSel <= 4'h0;
    wr(5'h04, 32'h0000_0000);
    wbSel <= 4'hF;
    wbCycle(1'b0, 5'h04, 32'h0000_0000);
    check("masked write", 32'h0000_1122, rdData);
    $display("test regs done");
  endtask : t_regs
  task automatic t_start;
    doReset(0);
    ticks(8);
    cnt("idle count", 14'h3FFF);
    wr(5'h04, 32'h0000_3310);
    refresh();
    cnt("start count", 14'h03FF);
    ticks(5);
    cnt("run count", 14'h03FA);
    wr(5'h00, 32'h0000_0000);
    wr(5'h00, 32'h0000_0055);
    wr(5'h00, 32'h0000_00FF);
    cnt("broken refresh", 14'h03FA);
    wr(5'h00, 32'h0000_0000);
    wr(5'h08, 32'h0000_0000);
    wr(5'h00, 32'h0000_00FF);
    cnt("refresh", 14'h03FF);
    $display("test start done");
  endtask : t_start
  task automatic t_prescale;
    logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hF, 4'h5};
    int divs [6] = '{1, 16, 32, 64, 128, 256};
    int d;
    for (int i = 0; i < 6; i++)
    begin
      doReset(0);
      wr(5'h04, {16'h0000, 8'h33, codes[i], 4'h0});
      refresh();
      ticks(2 * divs[i]);
      wbCycle(1'b0, 5'h10, 32'h0000_0000);
      d = 1023 - int'(rdData[13:0]);
      check("divided steps", 1, (d >= 1 && d <= 2));
    end
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_fault;
    int tops [4] = '{1023, 4095, 8191, 16383};
    int u0, r0, n0, i0;
    for (int i = 0; i < 4; i++)
    begin
      doReset(0);
      watchdogNmiEnable <= (i == 1);
      wr(5'h04, 32'h0000_3310 | i);
      wr(5'h08, (i == 2) ? 32'h0000_0080 : 32'h0000_0000);
      refresh();
      u0 = nUnder;
      r0 = nRst;
      n0 = nNmi;
      i0 = nIrq;
      ticks(tops[i]);
      check("early underflow", u0, nUnder);
      ticks(1);
      check("underflow", u0 + 1, nUnder);
      check("reset out", r0 + (i == 2), nRst);
      check("nmi out", n0 + (i == 1), nNmi);
      check("irq out", i0 + (i == 0 || i == 3), nIrq);
      ticks(8);
      cnt("halted", tops[i]);
      check("underflow flag", 1, rdData[14]);
    end
    $display("test fault done");
  endtask : t_fault
  task automatic t_window;
    int e0;
    doReset(0);
    wr(5'h04, 32'h0000_3010);
    refresh();
    ticks(100);
    e0 = nErr;
    refresh();
    cnt("window refresh", 14'h03FF);
    check("refresh in window", e0, nErr);
    ticks(300);
    refresh();
    cnt("halted after error", 14'h03FF);
    check("error flag", 1, rdData[15]);
    check("refresh out of window", e0 + 1, nErr);
    refresh();
    cnt("restart", 14'h03FF);
    check("error flag cleared", 0, rdData[15]);
    $display("test window done");
  endtask : t_window
  task automatic t_lowp;
    for (int s = 0; s < 2; s++)
    begin
      doReset(0);
      wr(5'h04, 32'h0000_3310);
      wr(5'h0C, s ? 32'h0000_0000 : 32'h0000_0080);
      refresh();
      lowPowerRequest <= 1;
      ticks(10);
      cnt("low power count", s ? 14'h03F5 : 14'h03FF);
      check("sleep stop out", s ? 32'h0 : 32'h1, {31'h0, sysOut.sleepStopOut});
      lowPowerRequest <= 0;
    end
    $display("test low power done");
  endtask : t_lowp
  task automatic t_auto;
    int r0;
    optionSettingWordZero <= {4'h1, 2'b00, 2'b11, 2'b11, 1'b1, 1'b0};
    doReset(1);
    ticks(6);
    cnt("auto count", 14'h03F9);
    r0 = nRst;
    ticks(1018);
    cnt("auto reload", 14'h03FF);
    check("auto reset out", r0 + 1, nRst);
    ticks(3);
    cnt("auto keeps running", 14'h03FC);
    $display("test auto done");
  endtask : t_auto
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Main sequence
  initial
  begin
    t_regs();
    t_start();
    t_prescale();
    t_fault();
    t_window();
    t_lowp();
    t_auto();
    test_done();
  end
  // Watchdog against a hang
  initial
  begin
    #1_000_000;
    mismatches++;
    test_done();
  end
endmodule : tb_independent_watchdog
